// >>> core/rate_limit_pkg.sv
package rate_limit_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int          APB_ADDR_WIDTH  = 18;
  localparam int          APB_DATA_WIDTH  = 32;
  localparam int          CODE_WIDTH      = 7;
  localparam int          FIRST_PORT      = 1;
  localparam int          LAST_PORT       = 7;

  // ----------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------
  localparam logic [11:0] IDX_INGRESS_PRIO4 = 12'h414;
  localparam logic [11:0] IDX_INGRESS_PRIO5 = 12'h415;
  localparam logic [11:0] IDX_INGRESS_PRIO6 = 12'h416;
  localparam logic [11:0] IDX_INGRESS_PRIO7 = 12'h417;
  localparam logic [11:0] IDX_EGRESS_QUEUE0 = 12'h420;
  localparam logic [11:0] IDX_EGRESS_QUEUE1 = 12'h421;
  localparam logic [11:0] IDX_EGRESS_QUEUE2 = 12'h422;
  localparam logic [11:0] IDX_EGRESS_QUEUE3 = 12'h423;
  localparam logic [15:0] IDX_GLOBAL_CTRL   = 16'h0300;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int          EGRESS_PORT_MODE_BIT = 3;
  localparam logic [6:0]  CODE_RESET           = 7'h00;
  localparam logic [6:0]  FULL_RATE_CODE       = 7'h00;
  localparam logic [31:0] GLOBAL_CTRL_RESET    = 32'h0000_0000;

  // ----------------------------------------
  // Bank write selects
  // ----------------------------------------
  typedef enum logic [2:0] {
    SEL_PRIO4  = 3'b000,
    SEL_PRIO5  = 3'b001,
    SEL_PRIO6  = 3'b010,
    SEL_PRIO7  = 3'b011,
    SEL_QUEUE0 = 3'b100,
    SEL_QUEUE1 = 3'b101,
    SEL_QUEUE2 = 3'b110,
    SEL_QUEUE3 = 3'b111
  } bank_sel_t;

  typedef struct packed {
    logic [6:0] prio7;
    logic [6:0] prio6;
    logic [6:0] prio5;
    logic [6:0] prio4;
  } ingress_codes_t;

  typedef struct packed {
    logic [6:0] queue3;
    logic [6:0] queue2;
    logic [6:0] queue1;
    logic [6:0] queue0;
  } egress_codes_t;

  typedef struct packed {
    logic       en;
    bank_sel_t  sel;
    logic [6:0] code;
  } bank_write_t;

endpackage

// >>> core/port_limit_bank.sv
`timescale 1ns/1ps
module port_limit_bank (
  // Clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           reset,
  // Write request from the bus slave
  input  wire rate_limit_pkg::bank_write_t    wr,
  // Staged and applied codes
  output rate_limit_pkg::ingress_codes_t      ingress_staged,
  output rate_limit_pkg::egress_codes_t       egress_staged,
  output rate_limit_pkg::ingress_codes_t      ingress_active,
  output rate_limit_pkg::egress_codes_t       egress_active
);
  import rate_limit_pkg::*;

  typedef struct packed {
    ingress_codes_t ing_stage;
    egress_codes_t  egr_stage;
    ingress_codes_t ing_act;
    egress_codes_t  egr_act;
  } bank_state_t;

  bank_state_t state;
  bank_state_t next_state;

  always_comb begin
    next_state = state;
    if (wr.en) begin
      case (wr.sel)
        SEL_PRIO4:  next_state.ing_stage.prio4 = wr.code;
        SEL_PRIO5:  next_state.ing_stage.prio5 = wr.code;
        SEL_PRIO6:  next_state.ing_stage.prio6 = wr.code;
        SEL_PRIO7: begin
          // Commit the whole ingress group at once
          next_state.ing_stage.prio7 = wr.code;
          next_state.ing_act         = next_state.ing_stage;
        end
        SEL_QUEUE0: next_state.egr_stage.queue0 = wr.code;
        SEL_QUEUE1: next_state.egr_stage.queue1 = wr.code;
        SEL_QUEUE2: next_state.egr_stage.queue2 = wr.code;
        SEL_QUEUE3: begin
          next_state.egr_stage.queue3 = wr.code;
          next_state.egr_act          = next_state.egr_stage;
        end
        default: next_state = state;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign ingress_staged = state.ing_stage;
  assign egress_staged  = state.egr_stage;
  assign ingress_active = state.ing_act;
  assign egress_active  = state.egr_act;

endmodule

// >>> core/port_rate_limit_regs.sv
// What this block does
// - Priority 4-6 ingress registers hold a 7-bit code, top bit reads zero.
// - Priority 4-6 codes only take effect when priority 7 is written.
// - Writing priority 7 applies its code plus all staged ingress codes.
// - Queue 0-3 egress registers hold a 7-bit code, top bit reads zero.
// - Queue 0-2 codes only take effect once queue 3 is written.
// - In whole-port egress mode only the queue 0 code limits the port.
// - Queue 1-3 codes are used only in per-queue egress mode.
// - Ports 1 to 7 each have their own copy, port in upper digit.
// - Each code is a scaled rate; code zero means full line rate.
`timescale 1ns/1ps
module port_rate_limit_regs (
  // Clock and reset
  input  wire logic                                   ref_clk,
  input  wire logic                                   reset,
  // APB slave
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [rate_limit_pkg::APB_ADDR_WIDTH-1:0] paddr,
  input  wire logic [rate_limit_pkg::APB_DATA_WIDTH-1:0] pwdata,
  input  wire logic [3:0]                             pstrb,
  output logic      [rate_limit_pkg::APB_DATA_WIDTH-1:0] prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  // Applied limits, index is the port number
  output rate_limit_pkg::ingress_codes_t [7:1]        ingress_limit,
  output rate_limit_pkg::egress_codes_t  [7:1]        egress_limit,
  output logic                                        egress_port_mode,
  output logic [7:1][3:0]                             ingress_full_rate,
  output logic [7:1][3:0]                             egress_full_rate
);
  import rate_limit_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic        err;
    logic [31:0] global_ctrl;
  } slave_state_t;

  slave_state_t            state;
  slave_state_t            next_state;

  ingress_codes_t [7:1]    ing_staged;
  egress_codes_t  [7:1]    egr_staged;
  ingress_codes_t [7:1]    ing_active;
  egress_codes_t  [7:1]    egr_active;
  bank_write_t    [7:1]    bank_wr;

  logic [15:0]             idx;
  logic [3:0]              port_digit;
  logic [11:0]             reg_off;
  logic                    port_ok;
  logic                    off_ok;
  logic                    is_global;
  logic                    mapped;
  logic                    setup_phase;
  logic                    write_commit;
  bank_sel_t               sel;
  logic [6:0]              rd_code;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign idx          = paddr[17:2];
  assign port_digit   = idx[15:12];
  assign reg_off      = idx[11:0];
  assign port_ok      = (port_digit >= 4'(FIRST_PORT)) && (port_digit <= 4'(LAST_PORT));
  assign is_global    = (idx == IDX_GLOBAL_CTRL);
  assign mapped       = (port_ok && off_ok) || is_global;
  assign setup_phase  = psel && !penable;
  // Zero wait states, so the access cycle is the commit edge
  assign write_commit = psel && penable && pwrite && !state.err;

  always_comb begin
    off_ok = 1'b1;
    sel    = SEL_PRIO4;
    case (reg_off)
      IDX_INGRESS_PRIO4: sel = SEL_PRIO4;
      IDX_INGRESS_PRIO5: sel = SEL_PRIO5;
      IDX_INGRESS_PRIO6: sel = SEL_PRIO6;
      IDX_INGRESS_PRIO7: sel = SEL_PRIO7;
      IDX_EGRESS_QUEUE0: sel = SEL_QUEUE0;
      IDX_EGRESS_QUEUE1: sel = SEL_QUEUE1;
      IDX_EGRESS_QUEUE2: sel = SEL_QUEUE2;
      IDX_EGRESS_QUEUE3: sel = SEL_QUEUE3;
      default:           off_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Read mux, staged copies shown
  // ----------------------------------------
  always_comb begin
    rd_code = CODE_RESET;
    for (int p = FIRST_PORT; p <= LAST_PORT; p++) begin
      if (port_digit == 4'(p)) begin
        case (sel)
          SEL_PRIO4:  rd_code = ing_staged[p].prio4;
          SEL_PRIO5:  rd_code = ing_staged[p].prio5;
          SEL_PRIO6:  rd_code = ing_staged[p].prio6;
          SEL_PRIO7:  rd_code = ing_staged[p].prio7;
          SEL_QUEUE0: rd_code = egr_staged[p].queue0;
          SEL_QUEUE1: rd_code = egr_staged[p].queue1;
          SEL_QUEUE2: rd_code = egr_staged[p].queue2;
          SEL_QUEUE3: rd_code = egr_staged[p].queue3;
          default:    rd_code = CODE_RESET;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Slave state update
  // ----------------------------------------
  always_comb begin
    next_state = state;
    if (setup_phase) begin
      next_state.err   = !mapped;
      next_state.rdata = 32'h0000_0000;
      if (is_global) begin
        next_state.rdata = state.global_ctrl;
      end else if (mapped) begin
        // Reserved top bit and upper lanes read as zero
        next_state.rdata = {25'h000_0000, rd_code};
      end
    end
    if (write_commit && is_global && pstrb[0]) begin
      next_state.global_ctrl[EGRESS_PORT_MODE_BIT] = pwdata[EGRESS_PORT_MODE_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state.rdata       <= 32'h0000_0000;
      state.err         <= 1'b0;
      state.global_ctrl <= GLOBAL_CTRL_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = state.rdata;
  assign pslverr = psel && penable && state.err;

  // ----------------------------------------
  // Per-port banks
  // ----------------------------------------
  generate
    for (genvar p = FIRST_PORT; p <= LAST_PORT; p++) begin : g_port
      // Only lane 0 carries the code; a write without it is dropped
      assign bank_wr[p].en   = write_commit && port_ok && off_ok && pstrb[0] &&
                               (port_digit == 4'(p));
      assign bank_wr[p].sel  = sel;
      assign bank_wr[p].code = pwdata[6:0];

      port_limit_bank u_bank (
        .ref_clk        (ref_clk),
        .reset          (reset),
        .wr             (bank_wr[p]),
        .ingress_staged (ing_staged[p]),
        .egress_staged  (egr_staged[p]),
        .ingress_active (ing_active[p]),
        .egress_active  (egr_active[p])
      );
    end
  endgenerate

  // ----------------------------------------
  // Limits seen by the datapath
  // ----------------------------------------
  assign egress_port_mode = state.global_ctrl[EGRESS_PORT_MODE_BIT];

  always_comb begin
    for (int p = FIRST_PORT; p <= LAST_PORT; p++) begin
      ingress_limit[p]         = ing_active[p];
      egress_limit[p].queue0   = egr_active[p].queue0;
      // Whole-port mode hides the per-queue codes as unlimited
      egress_limit[p].queue1   = egress_port_mode ? FULL_RATE_CODE : egr_active[p].queue1;
      egress_limit[p].queue2   = egress_port_mode ? FULL_RATE_CODE : egr_active[p].queue2;
      egress_limit[p].queue3   = egress_port_mode ? FULL_RATE_CODE : egr_active[p].queue3;
      ingress_full_rate[p][0]  = (ing_active[p].prio4 == FULL_RATE_CODE);
      ingress_full_rate[p][1]  = (ing_active[p].prio5 == FULL_RATE_CODE);
      ingress_full_rate[p][2]  = (ing_active[p].prio6 == FULL_RATE_CODE);
      ingress_full_rate[p][3]  = (ing_active[p].prio7 == FULL_RATE_CODE);
      egress_full_rate[p][0]   = (egress_limit[p].queue0 == FULL_RATE_CODE);
      egress_full_rate[p][1]   = (egress_limit[p].queue1 == FULL_RATE_CODE);
      egress_full_rate[p][2]   = (egress_limit[p].queue2 == FULL_RATE_CODE);
      egress_full_rate[p][3]   = (egress_limit[p].queue3 == FULL_RATE_CODE);
    end
  end

endmodule

// >>> testbench/rate_limit_sva.sv
`timescale 1ns/1ps
module rate_limit_sva
  import rate_limit_pkg::*;
(
  // Clock and reset
  input wire logic                      ref_clk,
  input wire logic                      reset,
  // APB
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [APB_ADDR_WIDTH-1:0] paddr,
  input wire logic [APB_DATA_WIDTH-1:0] pwdata,
  input wire logic [3:0]                pstrb,
  input wire logic [APB_DATA_WIDTH-1:0] prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  // Limits
  input wire ingress_codes_t [7:1]      ingress_limit,
  input wire egress_codes_t  [7:1]      egress_limit,
  input wire logic                      egress_port_mode,
  input wire logic [7:1][3:0]           ingress_full_rate,
  input wire logic [7:1][3:0]           egress_full_rate
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic [15:0] idx;
  logic        wacc, p7, q3, upper_clr, fr_ok;
  logic [3:0]  wport;
  logic [6:0]  wcode;
  assign idx  = paddr[17:2];
  assign wacc = psel && penable && pwrite && pstrb[0] && idx[15:12] >= 4'h1 && idx[15:12] <= 4'h7;
  // Flags land with the outputs they commit, so no $past is needed
  always_ff @(posedge ref_clk) begin
    wport <= idx[15:12];
    wcode <= pwdata[6:0];
    p7    <= wacc && idx[11:0] == IDX_INGRESS_PRIO7;
    q3    <= wacc && idx[11:0] == IDX_EGRESS_QUEUE3;
  end
  always_comb begin
    upper_clr = 1'b1;
    fr_ok     = 1'b1;
    for (int p = 1; p <= 7; p++) begin
      upper_clr &= egress_limit[p][27:7] == 21'h0;
      for (int k = 0; k < 4; k++) begin
        fr_ok &= ingress_full_rate[p][k] == (ingress_limit[p][7*k+:7] == 7'h00);
        fr_ok &= egress_full_rate[p][k] == (egress_limit[p][7*k+:7] == 7'h00);
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_err_access; pslverr |-> psel && penable; endproperty
  property p_unmapped;
    psel && penable && idx[15:12] == 4'h0 && idx != IDX_GLOBAL_CTRL |-> pslverr && prdata == 32'h0;
  endproperty
  property p_reserved_zero; psel && penable && !pwrite |-> prdata[31:7] == 25'h0; endproperty
  property p_ingress_hold; $changed(ingress_limit) |-> p7; endproperty
  property p_prio7_apply; p7 |-> ingress_limit[wport].prio7 == wcode; endproperty
  property p_egress_hold; $changed(egress_limit) |-> q3 || $changed(egress_port_mode); endproperty
  property p_queue3_apply; q3 && !egress_port_mode |-> egress_limit[wport].queue3 == wcode; endproperty
  property p_port_mode; egress_port_mode |-> upper_clr; endproperty
  property p_full_rate; fr_ok; endproperty
  a_err_access: assert property (p_err_access) else $error("error flag outside access");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
  a_ingress_hold: assert property (p_ingress_hold) else $error("ingress changed early");
  a_prio7_apply: assert property (p_prio7_apply) else $error("prio7 code wrong");
  a_egress_hold: assert property (p_egress_hold) else $error("egress changed early");
  a_queue3_apply: assert property (p_queue3_apply) else $error("queue3 code wrong");
  a_port_mode: assert property (p_port_mode) else $error("upper queues used");
  a_full_rate: assert property (p_full_rate) else $error("full rate flag wrong");
  c_ingress: cover property (p7);
  c_egress: cover property (q3);
  c_error: cover property (pslverr);
endmodule

bind port_rate_limit_regs rate_limit_sva u_sva (.ref_clk(ref_clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ingress_limit(ingress_limit), .egress_limit(egress_limit),
  .egress_port_mode(egress_port_mode), .ingress_full_rate(ingress_full_rate),
  .egress_full_rate(egress_full_rate));

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import rate_limit_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                 ref_clk, reset, psel, penable, pwrite, pready, pslverr, egress_port_mode, rerr;
  logic [17:0]          paddr;
  logic [31:0]          pwdata, prdata, rdata;
  logic [3:0]           pstrb, strb;
  ingress_codes_t [7:1] ingress_limit;
  egress_codes_t  [7:1] egress_limit;
  logic [7:1][3:0]      ingress_full_rate, egress_full_rate;
  int                   bad_count, samples_checked;
  logic [11:0]          regs [8] = '{IDX_INGRESS_PRIO4, IDX_INGRESS_PRIO5, IDX_INGRESS_PRIO6, IDX_INGRESS_PRIO7,
                                     IDX_EGRESS_QUEUE0, IDX_EGRESS_QUEUE1, IDX_EGRESS_QUEUE2, IDX_EGRESS_QUEUE3};
  // Bit 7 set on purpose: reserved bit must drop
  logic [31:0]          dv [4] = '{32'hA5, 32'h01, 32'hFF, 32'h80};

  port_rate_limit_regs dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ingress_limit(ingress_limit), .egress_limit(egress_limit), .egress_port_mode(egress_port_mode),
    .ingress_full_rate(ingress_full_rate), .egress_full_rate(egress_full_rate));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize;
    $display("mismatches %0d, checks %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Wait states are polled on pready; the watchdog ends a hang
  task automatic acc(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    // Strobes launch with the rest of the request, on the rising edge
    pstrb   <= strb;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rdata   = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge ref_clk);
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    bad_count       = 0;
    samples_checked = 0;
    reset           = 1'b1;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 18'h0;
    pwdata          = 32'h0;
    pstrb           = 4'hF;
    strb            = 4'hF;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      acc(1'b0, {4'h1, regs[i]}, 32'h0);
      chk(rdata, 32'h0, "reset value");
    end
    chk(32'(ingress_full_rate[1]), 32'hF, "reset full rate");
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, {4'h3, regs[i]}, dv[i]);
    end
    chk(32'(ingress_limit[3]), 32'h0, "ingress applied early");
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, {4'h3, regs[i]}, 32'h0);
      chk(rdata, {25'h0, dv[i][6:0]}, "staged readback");
    end
    acc(1'b1, {4'h3, regs[3]}, dv[3]);
    chk(32'(ingress_limit[3]), {4'h0, 7'h00, 7'h7F, 7'h01, 7'h25}, "ingress commit");
    chk(32'(ingress_full_rate[3]), 32'h8, "ingress full rate");
    chk(32'(ingress_limit[2]), 32'h0, "other port changed");
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, {4'h7, regs[4+i]}, 32'(32'h10 + 9 * i));
    end
    chk(32'(egress_limit[7]), 32'h0, "egress applied early");
    acc(1'b0, {4'h7, regs[5]}, 32'h0);
    chk(rdata, 32'h19, "egress staged readback");
    acc(1'b1, {4'h7, regs[7]}, 32'h2B);
    chk(32'(egress_limit[7]), {4'h0, 7'h2B, 7'h22, 7'h19, 7'h10}, "egress commit");
    acc(1'b1, IDX_GLOBAL_CTRL, 32'h8);
    chk({31'h0, egress_port_mode}, 32'h1, "port mode");
    chk(32'(egress_limit[7]), 32'h10, "port mode limits");
    chk(32'(egress_full_rate[7]), 32'hE, "egress full rate");
    acc(1'b0, IDX_GLOBAL_CTRL, 32'h0);
    chk(rdata, 32'h8, "port mode readback");
    acc(1'b1, IDX_GLOBAL_CTRL, 32'h0);
    chk(32'(egress_limit[7]), {4'h0, 7'h2B, 7'h22, 7'h19, 7'h10}, "queue mode limits");
    acc(1'b0, 16'h0414, 32'h0);
    chk({rdata[30:0], rerr}, 32'h1, "port 0 read");
    // Port 9 would alias onto port 1 if only three digit bits were decoded
    acc(1'b1, 16'h9417, 32'h55);
    chk({31'h0, rerr}, 32'h1, "port 9 write");
    chk(32'(ingress_limit[1]), 32'h0, "port 9 write leaked");
    strb = 4'h0;
    acc(1'b1, 16'h1417, 32'h55);
    strb = 4'hF;
    acc(1'b0, 16'h1417, 32'h0);
    chk(rdata, 32'h0, "strobe-less write");
    // Mid-run reset must clear applied and staged codes
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk(32'(ingress_limit[3]), 32'h0, "ingress after reset");
    chk(32'(egress_limit[7]), 32'h0, "egress after reset");
    acc(1'b0, {4'h3, regs[2]}, 32'h0);
    chk(rdata, 32'h0, "staged after reset");
    summarize;
  end
endmodule
